// file: hw/ocl_threshold.sv
// overcurrent threshold register of one phase, with its valley current comparator
// assumes word commands arrive already decoded from pmbus, one cycle each, synchronous to mclk_i
`timescale 1ns/100ps
module ocl_threshold (
    input  wire logic        mclk_i,        // 250 MHz clock
    input  wire logic        sys_rst_i,     // synchronous reset, active high
    input  wire logic        ce_i,          // clock enable, freezes all state when low
    input  wire logic        req_valid_i,   // one-cycle command strobe
    input  wire logic        req_write_i,   // 1 = word write, 0 = word read
    input  wire logic [7:0]  req_code_i,    // command code
    input  wire logic [7:0]  req_phase_i,   // phase selection, ff = whole stack
    input  wire logic [15:0] req_wdata_i,   // write word
    input  wire logic [4:0]  exp_cfg_i,     // exponent set by other configuration
    input  wire logic [2:0]  stack_count_i, // phases in the stack, 1 to 4
    input  wire logic [7:0]  own_phase_i,   // this device's phase number
    input  wire logic        primary_i,     // this device is the stack primary
    input  wire logic        restore_i,     // one-cycle start-up load strobe
    input  wire logic [7:0]  restore_val_i, // mantissa from nvm or strap detection
    input  wire logic [7:0]  valley_qa_i,   // sensed low-side valley current, quarter amperes
    output logic             ack_o,         // request taken
    output logic             nack_o,        // write data refused
    output logic             rvalid_o,      // read word valid
    output logic [15:0]      rdata_o,       // read word
    output logic             cml_set_o,     // set communication status flag
    output logic             ivd_set_o,     // set invalid data status flag
    output logic [7:0]       mant_o,        // stored mantissa
    output logic [7:0]       thr_qa_o,      // applied threshold, quarter amperes
    output logic             oc_fault_o     // overcurrent detected
);
    logic [7:0]  mant_q;     // stored mantissa, split per phase on a broadcast write
    logic [7:0]  thr_q;      // applied threshold
    logic        oc_q;       // fault flag
    logic        ack_q;      // answer pulses
    logic        nack_q;
    logic        rv_q;
    logic [15:0] rdata_q;    // read word register
    logic        hit;        // request addressed to this phase
    logic        bcast;      // broadcast stack access
    logic        bad_wr;     // write touches read-only bits
    logic [7:0]  new_mant;   // mantissa a good write would store
    logic [8:0]  sum_lvl;    // rounding sum for stack division
    logic [10:0] prod_lvl;   // level times stack count
    logic [7:0]  thr_d;      // nearest supported threshold

    // bin lookup: nearest supported setting below or at the value
    function automatic logic [3:0] ocl_bin(input logic [7:0] v, input logic three);
        logic [3:0] b;
        b = 4'h0;
        for (int i = 1; i < ocl_pkg::OCL_NBIN; i++) begin
            if (v >= (three ? ocl_pkg::OCL_BIN3_LO[i] : ocl_pkg::OCL_BIN_LO[i])) begin
                b = 4'(i);
            end
        end
        return b;
    endfunction

    // address decode and phase selection
    always_comb begin
        bcast = (req_phase_i == ocl_pkg::OCL_PHASE_ALL);
        hit   = ce_i && req_valid_i && (req_code_i == ocl_pkg::OCL_CMD_CODE)
                && (bcast || (req_phase_i == own_phase_i));
    end

    // level arithmetic for stack access
    always_comb begin
        sum_lvl  = 9'h000;
        new_mant = req_wdata_i[7:0];
        if (bcast && stack_count_i == ocl_pkg::OCL_STK_TWO) begin
            sum_lvl  = {1'b0, req_wdata_i[7:0]} + 9'h001;
            new_mant = sum_lvl[8:1];
        end else if (bcast && stack_count_i == ocl_pkg::OCL_STK_FOUR) begin
            sum_lvl  = {1'b0, req_wdata_i[7:0]} + 9'h002;
            new_mant = {1'b0, sum_lvl[8:2]};
        end else if (bcast && stack_count_i == ocl_pkg::OCL_STK_THREE) begin
            // three phases do not divide evenly, so a table bins the level
            new_mant = ocl_pkg::OCL_BIN_LO[ocl_bin(req_wdata_i[7:0], 1'b1)];
        end
        // widen before multiplying so a large level times the count keeps its top bits
        prod_lvl = 11'(mant_q) * 11'(stack_count_i);
    end

    // read-only bit check; exponent and reserved must match what reads back
    always_comb begin
        bad_wr = (req_wdata_i[ocl_pkg::OCL_EXP_MSB:ocl_pkg::OCL_EXP_LSB] != exp_cfg_i)
              || (req_wdata_i[ocl_pkg::OCL_RSV_MSB:ocl_pkg::OCL_RSV_LSB] != ocl_pkg::OCL_RSV_VAL);
        if (!bcast) begin
            if (req_wdata_i[ocl_pkg::OCL_STK7_BIT] != mant_q[ocl_pkg::OCL_STK7_BIT]
                && stack_count_i < ocl_pkg::OCL_STK_BIT7_MIN) begin
                bad_wr = 1'b1;
            end
            if (req_wdata_i[ocl_pkg::OCL_STK6_BIT] != mant_q[ocl_pkg::OCL_STK6_BIT]
                && stack_count_i < ocl_pkg::OCL_STK_BIT6_MIN) begin
                bad_wr = 1'b1;
            end
        end
    end

    // mantissa storage
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            mant_q <= ocl_pkg::OCL_MANT_RST;
        end else if (ce_i) begin
            if (restore_i) begin
                mant_q <= restore_val_i;
            end else if (hit && req_write_i && !bad_wr) begin
                mant_q <= new_mant;
            end
        end
    end

    // applied threshold, registered into thr_q one cycle after the mantissa changes, with no output disable needed
    always_comb begin
        thr_d = ocl_pkg::OCL_BIN_QA[ocl_bin(mant_q, 1'b0)];
    end

    // threshold register and comparator
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            thr_q <= ocl_pkg::OCL_BIN_QA[0];
            oc_q  <= 1'b0;
        end else if (ce_i) begin
            thr_q <= thr_d;
            oc_q  <= (valley_qa_i >= thr_q);
        end
    end

    // answer pulses and read word
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ack_q   <= 1'b0;
            nack_q  <= 1'b0;
            rv_q    <= 1'b0;
            rdata_q <= 16'h0000;
        end else if (ce_i) begin
            ack_q  <= 1'b0;
            nack_q <= 1'b0;
            rv_q   <= 1'b0;
            if (hit && req_write_i) begin
                ack_q  <= !bad_wr;
                nack_q <= bad_wr;
            end else if (hit && !bcast) begin
                ack_q   <= 1'b1;
                rv_q    <= 1'b1;
                rdata_q <= {exp_cfg_i, ocl_pkg::OCL_RSV_VAL, mant_q};
            end else if (hit && primary_i) begin
                // secondaries stay silent so only one device drives the bus
                ack_q   <= 1'b1;
                rv_q    <= 1'b1;
                rdata_q <= {exp_cfg_i, prod_lvl};
            end
        end
    end

    assign ack_o      = ack_q;
    assign nack_o     = nack_q;
    assign rvalid_o   = rv_q;
    assign rdata_o    = rdata_q;
    assign cml_set_o  = nack_q;
    assign ivd_set_o  = nack_q;
    assign mant_o     = mant_q;
    assign thr_qa_o   = thr_q;
    assign oc_fault_o = oc_q;

    // refused write leaves mantissa unchanged; a restore in the same cycle still wins
    property p_nack_keeps;
        @(posedge mclk_i) disable iff (sys_rst_i)
        nack_o |-> ($past(restore_i) || (mant_q == $past(mant_q))) && ivd_set_o && cml_set_o && !ack_o;
    endproperty
    a_nack_keeps: assert property (p_nack_keeps) else $error("refused write changed value");

    // reserved field reads zero on a single-phase read
    property p_rsv_zero;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (hit && !req_write_i && !bcast) |=> rvalid_o && (rdata_o[10:8] == 3'h0) && (rdata_o[7:0] == $past(mant_q));
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("read word wrong");

    // exponent reads back from configuration
    property p_exp_read;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (hit && !req_write_i && (!bcast || primary_i)) |=> rdata_o[15:11] == $past(exp_cfg_i);
    endproperty
    a_exp_read: assert property (p_exp_read) else $error("exponent not from configuration");

    // bit 7 holds in stacks under three, except on a broadcast access
    property p_bit7_lock;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (ce_i && !restore_i && stack_count_i < 3'h3 && !bcast) |=> mant_q[7] == $past(mant_q[7]);
    endproperty
    a_bit7_lock: assert property (p_bit7_lock) else $error("bit 7 changed in small stack");

    // bit 6 holds in a single phase, except on a broadcast access
    property p_bit6_lock;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (ce_i && !restore_i && stack_count_i < 3'h2 && !bcast) |=> mant_q[6] == $past(mant_q[6]);
    endproperty
    a_bit6_lock: assert property (p_bit6_lock) else $error("bit 6 changed in single phase");

    // good single-phase write stores its low bits as written and acks
    property p_write_store;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (hit && req_write_i && !bad_wr && !bcast && !restore_i)
            |=> ack_o && (mant_q[5:0] == $past(req_wdata_i[5:0]));
    endproperty
    a_write_store: assert property (p_write_store) else $error("write not stored");

    // two-phase broadcast halves the level rounding up
    property p_bcast_two;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (hit && req_write_i && bcast && !bad_wr && !restore_i && stack_count_i == 3'h2)
            |=> mant_q == 8'(($past({1'b0, req_wdata_i[7:0]}) + 9'h001) >> 1);
    endproperty
    a_bcast_two: assert property (p_bcast_two) else $error("two-phase split wrong");

    // secondary stays silent on broadcast read
    property p_bcast_read;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (hit && !req_write_i && bcast) |=> (rvalid_o == $past(primary_i))
            && (!rvalid_o || rdata_o[10:0] == 11'($past(mant_q)) * 11'($past(stack_count_i)));
    endproperty
    a_bcast_read: assert property (p_bcast_read) else $error("broadcast read answer wrong");

    // comparator follows threshold one cycle after a change
    property p_fault_cmp;
        @(posedge mclk_i) disable iff (sys_rst_i)
        // the edge right after reset shows the cleared flag, not a compare
        (ce_i && $past(ce_i) && !$past(sys_rst_i)) |-> oc_fault_o == ($past(valley_qa_i) >= $past(thr_qa_o));
    endproperty
    a_fault_cmp: assert property (p_fault_cmp) else $error("fault flag wrong");

    // restore strobe loads start-up value
    property p_restore;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (ce_i && restore_i) |=> mant_q == $past(restore_val_i);
    endproperty
    a_restore: assert property (p_restore) else $error("restore not loaded");
endmodule

// file: include/ocl_pkg.sv
// constants for the overcurrent threshold register block
// assumes a single 250 MHz clock and a command port fed by a pmbus front end
package ocl_pkg;
    // command codes
    localparam logic [7:0]  OCL_CMD_CODE      = 8'h46;   // overcurrent threshold command
    localparam logic [7:0]  OCL_PHASE_ALL     = 8'hff;   // phase value meaning broadcast stack access
    // field layout of the 16-bit word
    localparam int          OCL_EXP_MSB       = 15;      // exponent field top bit
    localparam int          OCL_EXP_LSB       = 11;      // exponent field bottom bit
    localparam int          OCL_RSV_MSB       = 10;      // reserved field top bit
    localparam int          OCL_RSV_LSB       = 8;       // reserved field bottom bit
    localparam int          OCL_STK7_BIT      = 7;       // mantissa bit gated by stack of three or more
    localparam int          OCL_STK6_BIT      = 6;       // mantissa bit gated by stack of two or more
    // values after reset
    localparam logic [7:0]  OCL_MANT_RST      = 8'h00;   // mantissa before the restore strobe
    localparam logic [2:0]  OCL_RSV_VAL       = 3'h0;    // reserved bits read zero on a single-phase read
    // stack counts at which the upper mantissa bits open
    localparam logic [2:0]  OCL_STK_BIT6_MIN  = 3'h2;    // bit 6 writable from two phases
    localparam logic [2:0]  OCL_STK_BIT7_MIN  = 3'h3;    // bit 7 writable from three phases
    localparam logic [2:0]  OCL_STK_TWO       = 3'h2;    // two-phase stack
    localparam logic [2:0]  OCL_STK_THREE     = 3'h3;    // three-phase stack
    localparam logic [2:0]  OCL_STK_FOUR      = 3'h4;    // four-phase stack
    // supported settings: lower mantissa bound of each bin
    localparam int          OCL_NBIN          = 14;      // number of supported thresholds
    localparam logic [7:0]  OCL_BIN_LO [OCL_NBIN] = '{
        8'h00, 8'h0e, 8'h11, 8'h16, 8'h19, 8'h1c, 8'h21,
        8'h25, 8'h27, 8'h2a, 8'h2f, 8'h32, 8'h35, 8'h3a};
    // lower bounds of the three-phase stack level bins
    localparam logic [7:0]  OCL_BIN3_LO [OCL_NBIN] = '{
        8'h00, 8'h2a, 8'h33, 8'h40, 8'h4b, 8'h55, 8'h62,
        8'h6d, 8'h75, 8'h7e, 8'h8b, 8'h94, 8'h9e, 8'had};
    // applied threshold of each bin in quarter amperes
    localparam logic [7:0]  OCL_BIN_QA [OCL_NBIN] = '{
        8'h32, 8'h3c, 8'h4b, 8'h5f, 8'h69, 8'h78, 8'h8c,
        8'h96, 8'ha0, 8'haf, 8'hc3, 8'hc8, 8'hdc, 8'hf0};
endpackage

// file: sim/ocl_host.sv
// pmbus host model: word reads and writes on the decoded command port
// assumes the device answers in the cycle after the edge that takes a request
`timescale 1ns/100ps
module ocl_host (
    input  wire logic        mclk_i,   // device clock
    input  wire logic        ack_i,    // request taken
    input  wire logic        nack_i,   // write refused
    input  wire logic        rvalid_i, // read word valid
    input  wire logic [15:0] rdata_i,  // read word
    output logic             valid_o,  // one-cycle request strobe
    output logic             write_o,  // word write when high
    output logic [7:0]       code_o,   // command code
    output logic [7:0]       phase_o,  // phase selection
    output logic [15:0]      wdata_o   // write word
);
    // idle bus at time zero
    initial begin
        valid_o = 1'b0;
        write_o = 1'b0;
        code_o  = 8'h00;
        phase_o = 8'h00;
        wdata_o = 16'h0000;
    end
    // one word transfer; whole word per request, answer taken after the taking edge
    task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] p, input logic [15:0] d,
                        output logic [3:0] ans, output logic [15:0] rd);
        @(posedge mclk_i);
        valid_o <= 1'b1;
        write_o <= w;
        code_o  <= c;
        phase_o <= p;
        wdata_o <= d;
        @(posedge mclk_i);
        valid_o <= 1'b0;
        // released data and code lines flip so no stale word survives
        wdata_o <= ~d;
        code_o  <= ~c;
        #1;
        ans = {ack_i, nack_i, rvalid_i, 1'b0};
        rd  = rdata_i;
    endtask
endmodule

// file: sim/overcurrent_limit_register_tb.sv
// self-checking bench of the overcurrent threshold register
// assumes the host model drives the command port and a 250 MHz clock
`timescale 1ns/100ps
module overcurrent_limit_register_tb;
    localparam logic [4:0] E = 5'h01;        // configured exponent
    logic        mclk_i = 1'b0;              // clock
    logic        sys_rst_i = 1'b1;           // reset
    logic        restore_i = 1'b0;           // start-up load strobe
    logic        primary = 1'b1;             // stack primary
    logic        ce = 1'b1;                  // clock enable
    logic [2:0]  stk = 3'h1;                 // stack count
    logic [7:0]  rval = 8'h00;               // restore value
    logic [7:0]  valley = 8'h00;             // sensed valley current
    logic [31:0] rng = 32'hbccb;             // xorshift state
    logic [3:0]  ans;                        // last answer flags
    logic [15:0] rd;                         // last read word
    logic        vld, wr_n, ack, nack, rv, cml, ivd, oc;
    logic [7:0]  code, ph, mant, thr;
    logic [15:0] wd, rdata;
    int          error_cnt = 0, tests_run = 0, cyc = 0, m = 0, lv = 0, s = 0;
    ocl_host h (.mclk_i(mclk_i), .ack_i(ack), .nack_i(nack), .rvalid_i(rv), .rdata_i(rdata), .valid_o(vld),
                .write_o(wr_n), .code_o(code), .phase_o(ph), .wdata_o(wd));
    ocl_threshold dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .req_valid_i(vld),
        .req_write_i(wr_n), .req_code_i(code), .req_phase_i(ph), .req_wdata_i(wd), .exp_cfg_i(E),
        .stack_count_i(stk), .own_phase_i(8'h01), .primary_i(primary), .restore_i(restore_i),
        .restore_val_i(rval), .valley_qa_i(valley), .ack_o(ack), .nack_o(nack), .rvalid_o(rv), .rdata_o(rdata),
        .cml_set_o(cml), .ivd_set_o(ivd), .mant_o(mant), .thr_qa_o(thr), .oc_fault_o(oc));
    // clock, 4 ns period
    initial forever #2 mclk_i = ~mclk_i;
    // hang guard: far above the few hundred cycles the run needs
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("unexpected at %0t: run did not end", $time);
            finish_test();
        end
    end
    task automatic finish_test;
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    endfunction
    // model of the applied setting: bin whose lower bound the mantissa reaches
    function automatic logic [7:0] bin_qa(input int v);
        bin_qa = ocl_pkg::OCL_BIN_QA[0];
        for (int i = 1; i < ocl_pkg::OCL_NBIN; i++)
            if (v >= ocl_pkg::OCL_BIN_LO[i]) bin_qa = ocl_pkg::OCL_BIN_QA[i];
    endfunction
    // model of a three-phase broadcast: lower bound of the phase bin the stack level falls in
    function automatic int bin3_lo(input int v);
        bin3_lo = ocl_pkg::OCL_BIN_LO[0];
        for (int i = 1; i < ocl_pkg::OCL_NBIN; i++)
            if (v >= ocl_pkg::OCL_BIN3_LO[i]) bin3_lo = ocl_pkg::OCL_BIN_LO[i];
    endfunction
    // write, answer flags, stored value, then applied threshold a cycle later
    task automatic wr(input logic [7:0] p, input logic [15:0] d, input logic ok, input int nm);
        h.xfer(1'b1, 8'h46, p, d, ans, rd);
        chk({10'h0, ans, cml, ivd}, ok ? 16'h0020 : 16'h0013, "write answer");
        if (ok) m = nm;
        chk({8'h0, mant}, m[7:0], "mantissa");
        @(posedge mclk_i);
        #1;
        chk({8'h0, thr}, bin_qa(m), "threshold");
    endtask
    task automatic rdw(input logic [7:0] p, input logic ok, input logic [15:0] exp);
        h.xfer(1'b0, 8'h46, p, 16'h0000, ans, rd);
        chk({12'h0, ans}, ok ? 16'h000a : 16'h0000, "read answer");
        if (ok) chk(rd, exp, "read word");
    endtask
    task automatic set_stk(input int n);
        @(posedge mclk_i);
        stk <= n[2:0];
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        #1;
        chk({mant, thr}, 16'h0032, "reset values");
        @(posedge mclk_i);
        restore_i <= 1'b1;
        rval <= 8'h27;
        @(posedge mclk_i);
        restore_i <= 1'b0;
        m = 8'h27;
        #1;
        chk({8'h0, mant}, m[7:0], "restored");
        rdw(8'h01, 1'b1, {E, 3'b000, m[7:0]});
        // random low bits, nearest bin applied, fault compare a cycle after the valley current changes
        repeat (20) begin
            rng = xs(rng);
            wr(8'h01, {E, 3'b000, 2'b00, rng[5:0]}, 1'b1, rng[5:0]);
            rdw(8'h01, 1'b1, {E, 3'b000, m[7:0]});
            @(posedge mclk_i);
            valley <= rng[15:8];
            @(posedge mclk_i);
            #1;
            chk({15'h0, oc}, {15'h0, rng[15:8] >= bin_qa(m)}, "fault flag");
        end
        wr(8'h01, {E, 3'b000, m[7:0] | 8'h40}, 1'b0, m);
        set_stk(2);
        wr(8'h01, {E, 3'b000, m[7:0] | 8'h80}, 1'b0, m);
        wr(8'h01, {E, 3'b000, m[7:0] | 8'h40}, 1'b1, m | 8'h40);
        set_stk(3);
        wr(8'h01, {E, 3'b000, m[7:0] | 8'h80}, 1'b1, m | 8'h80);
        // level with its top bits set: the product needs ten bits
        rdw(8'hff, 1'b1, {E, 11'(m * 3)});
        wr(8'h01, {E ^ 5'h01, 3'b000, m[7:0]}, 1'b0, m);
        wr(8'h01, {E, 3'b001, m[7:0]}, 1'b0, m);
        rdw(8'h02, 1'b0, 16'h0000);
        h.xfer(1'b0, 8'h47, 8'h01, 16'h0000, ans, rd);
        chk({12'h0, ans}, 16'h0000, "foreign code");
        // clock enable low: request ignored, value frozen
        @(posedge mclk_i);
        ce <= 1'b0;
        h.xfer(1'b1, 8'h46, 8'h01, {E, 3'b000, m[7:0] ^ 8'h01}, ans, rd);
        chk({12'h0, ans}, 16'h0000, "frozen answer");
        chk({8'h0, mant}, m[7:0], "frozen mantissa");
        @(posedge mclk_i);
        ce <= 1'b1;
        // broadcast write divides, broadcast read multiplies; three phases go through the bin table
        for (s = 2; s <= 4; s++) begin
            set_stk(s);
            rng = xs(rng);
            lv = rng[7:0];
            wr(8'hff, {E, 3'b000, rng[7:0]}, 1'b1, (s == 3) ? bin3_lo(lv) : (lv + s / 2) >> (s / 2));
            rdw(8'hff, 1'b1, {E, 11'(m * s)});
        end
        @(posedge mclk_i);
        primary <= 1'b0;
        rdw(8'hff, 1'b0, 16'h0000);
        // reset in mid-run with a high valley current: values fall back until the next restore
        @(posedge mclk_i);
        sys_rst_i <= 1'b1;
        valley <= 8'hff;
        repeat (2) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        #1;
        chk({mant, thr}, 16'h0032, "reset again");
        chk({15'h0, oc}, 16'h0000, "fault after reset");
        @(posedge mclk_i);
        #1;
        chk({15'h0, oc}, {15'h0, 8'hff >= bin_qa(0)}, "fault after release");
        finish_test();
    end
endmodule
